// ---- rtl/two_stage_event_controller.sv ----
// Two-stage event controller: system stage routing and core stage latching
`timescale 1ns/1ps
`include "event_ctrl_map.svh"

// Behaviour
// - Core stage holds sixteen-bit latch, mask and pending registers.
// - Latch bit sets on capture, clears by itself once event is accepted.
// - Software latch writes take effect only on bits whose mask is zero.
// - Mask one lets a latched event be serviced; zero blocks but keeps it.
// - Core mask readable and writable only in supervisor mode.
// - Global enable for general inputs, set and cleared by instructions.
// - Pending bit set while event active or nested; supervisor read only.
// - System stage has 32-bit mask, status and wakeup-enable registers.
// - System mask one passes a peripheral request; zero blocks it.
// - Status bit reads one while its peripheral asserts request, delayed by the two synchroniser cycles.
// - Wakeup-enabled source wakes the processor when idle or asleep.
// - System stage uses core pending as acknowledgement of forwarded request.
// - Latch sets on rising edge at event input; detection takes two cycles.
// - Latch bit clears when its pending bit sets.
// - After pending sets, the next rising edge is recognised and queued.
// - At least three cycles from general input edge to pending asserting.
// - Sixteen positions, zero highest; higher preempts lower, nesting allowed.
// - Positions 7 to 15 are the nine general inputs from the system stage.
// - Assignment registers route each source to a general input, default map.
module two_stage_event_controller (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Register port
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    output logic      [31:0] regRdata,
    input  wire logic        supervisor,
    // Peripheral request pins and dedicated core events 0..6
    input  wire logic [31:0] peripheralRequest,
    input  wire logic [6:0]  dedicatedEvent,
    // Sequencer side
    input  wire logic        enableInterrupts,
    input  wire logic        disableInterrupts,
    input  wire logic        acceptReady,
    input  wire logic        eventReturn,
    input  wire logic        coreIdle,
    output logic             eventTake,
    output logic      [3:0]  eventIndex,
    output logic      [15:0] pendingEvents,
    output logic             wakeRequest
);

    // ======================================================================
    // Declarations
    localparam int NEV = `CORE_EVENTS;
    localparam int NSRC = `SYSTEM_SOURCES;
    localparam int NGP = `GP_INPUTS;
    localparam int GP0 = `GP_FIRST;
    localparam int FB = `ASSIGN_FIELD_BITS;
    localparam int FPR = `ASSIGN_FIELDS_PER_REG;

    event_ctrl_pkg::core_vec_t     coreEventLatch;
    event_ctrl_pkg::core_vec_t     coreEventMask;
    event_ctrl_pkg::core_vec_t     coreEventPending;
    event_ctrl_pkg::source_vec_t   systemSourceMask;
    event_ctrl_pkg::source_vec_t   systemSourceStatus;
    event_ctrl_pkg::source_vec_t   systemWakeupEnable;
    event_ctrl_pkg::assign_field_t sourceAssignment [NSRC];
    logic                          globalEnable;

    logic [6:0]                    dedicatedSynced;
    logic [NGP-1:0]                gpCombined;
    logic [NGP-1:0]                gpRequest;
    logic [NGP-1:0]                ackHold;
    event_ctrl_pkg::core_vec_t     eventInput;
    event_ctrl_pkg::core_vec_t     eventInputDly;
    event_ctrl_pkg::core_vec_t     edgeSeen;
    event_ctrl_pkg::core_vec_t     pendingDly;

    event_ctrl_pkg::core_vec_t     eligible;
    event_ctrl_pkg::core_vec_t     takeVec;
    event_ctrl_pkg::core_vec_t     returnVec;
    event_ctrl_pkg::event_index_t  pickIndex;
    logic                          pickValid;
    logic [4:0]                    currentLevel;
    logic                          take;

    logic                          wrLatch;
    logic                          wrMask;
    logic                          wrSysMask;
    logic                          wrWakeup;
    logic [3:0]                    wrAssign;

    // ======================================================================
    // Input synchronisation
    pin_synchronizer #(
        .WIDTH (NSRC)
    ) uSyncSources (
        .clock  (clock),
        .rst_b  (rst_b),
        .async  (peripheralRequest),
        .synced (systemSourceStatus)
    );

    pin_synchronizer #(
        .WIDTH (7)
    ) uSyncDedicated (
        .clock  (clock),
        .rst_b  (rst_b),
        .async  (dedicatedEvent),
        .synced (dedicatedSynced)
    );

    // ======================================================================
    // Write decode; all register writes need supervisor mode
    always_comb begin
        wrLatch   = 1'b0;
        wrMask    = 1'b0;
        wrSysMask = 1'b0;
        wrWakeup  = 1'b0;
        wrAssign  = 4'h0;
        if (regWrite && supervisor) begin
            if (regAddr == `OFS_CORE_EVENT_LATCH) begin
                wrLatch = 1'b1;
            end else if (regAddr == `OFS_CORE_EVENT_MASK) begin
                wrMask = 1'b1;
            end else if (regAddr == `OFS_SYSTEM_SOURCE_MASK) begin
                wrSysMask = 1'b1;
            end else if (regAddr == `OFS_SYSTEM_WAKEUP_ENABLE) begin
                wrWakeup = 1'b1;
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT0) begin
                wrAssign = 4'h1;
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT1) begin
                wrAssign = 4'h2;
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT2) begin
                wrAssign = 4'h4;
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT3) begin
                wrAssign = 4'h8;
            end
        end
    end

    // ======================================================================
    // System stage: mask, wakeup enable and assignment registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            systemSourceMask <= `RST_SYSTEM_SOURCE_MASK;
        end else if (wrSysMask) begin
            systemSourceMask <= regWdata;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            systemWakeupEnable <= `RST_SYSTEM_WAKEUP_ENABLE;
        end else if (wrWakeup) begin
            systemWakeupEnable <= regWdata;
        end
    end

    genvar s;
    generate
        for (s = 0; s < NSRC; s++) begin : gAssign
            // Default spreads sources round-robin over the general inputs
            localparam logic [FB-1:0] DEF = FB'(s % NGP);
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    sourceAssignment[s] <= DEF;
                end else if (wrAssign[s / FPR]) begin
                    sourceAssignment[s] <=
                        regWdata[(s % FPR) * FB +: FB];
                end
            end
        end
    endgenerate

    // Merge unmasked sources per general input
    always_comb begin
        gpCombined = '0;
        for (int g = 0; g < NGP; g++) begin
            for (int k = 0; k < NSRC; k++) begin
                if (systemSourceStatus[k] && systemSourceMask[k]
                    && sourceAssignment[k] == FB'(g)) begin
                    gpCombined[g] = 1'b1;
                end
            end
        end
    end

    // A pending rise acknowledges the input; dropping the request for one
    // cycle lets a source that is still asserting make a fresh edge, since
    // several sources may share the input and would otherwise be lost
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ackHold <= '0;
        end else begin
            ackHold <= coreEventPending[GP0 +: NGP]
                       & ~pendingDly[GP0 +: NGP];
        end
    end

    assign gpRequest = gpCombined & ~ackHold;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wakeRequest <= 1'b0;
        end else begin
            wakeRequest <= coreIdle
                && |(systemSourceStatus & systemWakeupEnable);
        end
    end

    // ======================================================================
    // Core stage: edge detection
    assign eventInput = {gpRequest, dedicatedSynced};

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eventInputDly <= '0;
            edgeSeen      <= '0;
            pendingDly    <= `RST_CORE_EVENT_PENDING;
        end else begin
            eventInputDly <= eventInput;
            edgeSeen      <= eventInput & ~eventInputDly;
            pendingDly    <= coreEventPending;
        end
    end

    // ======================================================================
    // Core stage: priority and nesting
    always_comb begin
        eligible = coreEventLatch & coreEventMask;
        if (!globalEnable) begin
            eligible[NEV-1:GP0] = '0;
        end
    end

    always_comb begin
        pickValid = 1'b0;
        pickIndex = '0;
        for (int i = NEV - 1; i >= 0; i--) begin
            if (eligible[i]) begin
                pickValid = 1'b1;
                pickIndex = 4'(i);
            end
        end
    end

    // Innermost active level; 16 means nothing is active
    always_comb begin
        currentLevel = 5'h10;
        returnVec    = '0;
        for (int i = NEV - 1; i >= 0; i--) begin
            if (coreEventPending[i]) begin
                currentLevel = 5'(i);
            end
        end
        if (eventReturn && currentLevel != 5'h10) begin
            returnVec[currentLevel[3:0]] = 1'b1;
        end
    end

    // Only a strictly higher priority may nest over the active level
    assign take = pickValid && acceptReady
                  && ({1'b0, pickIndex} < currentLevel);

    always_comb begin
        takeVec = '0;
        if (take) begin
            takeVec[pickIndex] = 1'b1;
        end
    end

    // ======================================================================
    // Core stage registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            globalEnable <= `RST_GLOBAL_ENABLE;
        end else if (enableInterrupts) begin
            globalEnable <= 1'b1;
        end else if (disableInterrupts) begin
            globalEnable <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coreEventMask <= `RST_CORE_EVENT_MASK;
        end else if (wrMask) begin
            coreEventMask <= regWdata[NEV-1:0];
        end
    end

    // A fresh edge wins over both the entry clear and a software write
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coreEventLatch <= `RST_CORE_EVENT_LATCH;
        end else if (wrLatch) begin
            coreEventLatch <= ((coreEventLatch & ~takeVec & coreEventMask)
                               | (regWdata[NEV-1:0] & ~coreEventMask))
                              | edgeSeen;
        end else begin
            coreEventLatch <= (coreEventLatch & ~takeVec)
                              | edgeSeen;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            coreEventPending <= `RST_CORE_EVENT_PENDING;
        end else begin
            coreEventPending <= (coreEventPending & ~returnVec)
                                | takeVec;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            eventTake  <= 1'b0;
            eventIndex <= '0;
        end else begin
            eventTake <= take;
            if (take) begin
                eventIndex <= pickIndex;
            end
        end
    end

    assign pendingEvents = coreEventPending;

    // ======================================================================
    // Read data; outside supervisor mode every register reads zero
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            regRdata <= '0;
        end else if (regRead) begin
            regRdata <= '0;
            if (!supervisor) begin
                regRdata <= '0;
            end else if (regAddr == `OFS_CORE_EVENT_LATCH) begin
                regRdata <= {16'h0000, coreEventLatch};
            end else if (regAddr == `OFS_CORE_EVENT_MASK) begin
                regRdata <= {16'h0000, coreEventMask};
            end else if (regAddr == `OFS_CORE_EVENT_PENDING) begin
                regRdata <= {16'h0000, coreEventPending};
            end else if (regAddr == `OFS_SYSTEM_SOURCE_MASK) begin
                regRdata <= systemSourceMask;
            end else if (regAddr == `OFS_SYSTEM_SOURCE_STATUS) begin
                regRdata <= systemSourceStatus;
            end else if (regAddr == `OFS_SYSTEM_WAKEUP_ENABLE) begin
                regRdata <= systemWakeupEnable;
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT0) begin
                regRdata <= packAssign(0);
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT1) begin
                regRdata <= packAssign(1);
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT2) begin
                regRdata <= packAssign(2);
            end else if (regAddr == `OFS_SOURCE_ASSIGNMENT3) begin
                regRdata <= packAssign(3);
            end
        end
    end

    function automatic logic [31:0] packAssign(input int reg_n);
        logic [31:0] word;
        word = '0;
        for (int f = 0; f < FPR; f++) begin
            word[f * FB +: FB] = sourceAssignment[reg_n * FPR + f];
        end
        return word;
    endfunction

endmodule

// ---- rtl/event_ctrl_map.svh ----
// Register offsets, field layout and reset values of the event controller
`ifndef EVENT_CTRL_MAP_SVH
`define EVENT_CTRL_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses on the register port)
`define OFS_CORE_EVENT_LATCH      8'h00
`define OFS_CORE_EVENT_MASK       8'h04
`define OFS_CORE_EVENT_PENDING    8'h08
`define OFS_SYSTEM_SOURCE_MASK    8'h0C
`define OFS_SYSTEM_SOURCE_STATUS  8'h10
`define OFS_SYSTEM_WAKEUP_ENABLE  8'h14
`define OFS_SOURCE_ASSIGNMENT0    8'h18
`define OFS_SOURCE_ASSIGNMENT1    8'h1C
`define OFS_SOURCE_ASSIGNMENT2    8'h20
`define OFS_SOURCE_ASSIGNMENT3    8'h24

// ==========================================================================
// Field layout
`define CORE_EVENTS               16
`define SYSTEM_SOURCES            32
`define GP_FIRST                  7
`define GP_INPUTS                 9
`define ASSIGN_FIELD_BITS         4
`define ASSIGN_FIELDS_PER_REG     8

// ==========================================================================
// Reset values
`define RST_CORE_EVENT_LATCH      16'h0000
`define RST_CORE_EVENT_MASK       16'h0000
`define RST_CORE_EVENT_PENDING    16'h0000
`define RST_SYSTEM_SOURCE_MASK    32'h00000000
`define RST_SYSTEM_WAKEUP_ENABLE  32'h00000000
`define RST_GLOBAL_ENABLE         1'b0

// ==========================================================================
// Timing in core clocks
`define EDGE_DETECT_CYCLES        2
`define SYNC_STAGES               2

`endif

// ---- rtl/event_ctrl_pkg.sv ----
// Types shared by the event controller files
package event_ctrl_pkg;

    typedef logic [15:0] core_vec_t;
    typedef logic [31:0] source_vec_t;
    typedef logic [3:0]  event_index_t;
    typedef logic [3:0]  assign_field_t;

endpackage

// ---- rtl/pin_synchronizer.sv ----
// Two-flop synchroniser bank for asynchronous request pins
`timescale 1ns/1ps

module pin_synchronizer #(
    parameter int WIDTH = 32
) (
    input  wire logic             clock,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] async,
    output logic      [WIDTH-1:0] synced
);

    // ======================================================================
    // Per-bit double flop; the first stage feeds only the second
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : gBit
            logic meta;
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    meta      <= 1'b0;
                    synced[i] <= 1'b0;
                end else begin
                    meta      <= async[i];
                    synced[i] <= meta;
                end
            end
        end
    endgenerate

endmodule

// ---- verif/two_stage_event_controller_chk.sv ----
// Port checker for the two-stage event controller
`timescale 1ns/1ps

// ==========================================================================
// Checker
module two_stage_event_controller_chk (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        regRead,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regRdata,
    input  wire logic        supervisor,
    input  wire logic        enableInterrupts,
    input  wire logic        disableInterrupts,
    input  wire logic        acceptReady,
    input  wire logic        coreIdle,
    input  wire logic        eventTake,
    input  wire logic [3:0]  eventIndex,
    input  wire logic [15:0] pendingEvents,
    input  wire logic        wakeRequest
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    sequence s_newPend;
        |(pendingEvents & ~$past(pendingEvents));
    endsequence
    sequence s_gpOff;
        disableInterrupts && !enableInterrupts ##1 !enableInterrupts [*2];
    endsequence

    a_reset_quiet:
        assert property ($rose(rst_b) |-> pendingEvents == 16'h0)
        else $error("pending set after reset");
    a_take_follows:
        assert property (s_newPend |-> eventTake)
        else $error("no take with pending rise");
    a_take_index:
        assert property (eventTake |-> pendingEvents[eventIndex])
        else $error("taken index not pending");
    a_index_hold:
        assert property (!eventTake |-> $stable(eventIndex))
        else $error("index moved without take");
    a_pend_ready:
        assert property (s_newPend |-> $past(acceptReady))
        else $error("event entered while not ready");
    a_gp_disabled:
        assert property (s_gpOff |-> ((pendingEvents & ~$past(pendingEvents))
                                      & 16'hFF80) == 16'h0)
        else $error("general event taken while disabled");
    a_wake_idle:
        assert property (wakeRequest |-> $past(coreIdle))
        else $error("wake while core busy");
    a_user_read:
        assert property (regRead && !supervisor |=> regRdata == 32'h0)
        else $error("user read returned data");
    a_rdata_hold:
        assert property (!regRead |=> $stable(regRdata))
        else $error("read data moved without read");
    a_core_upper:
        assert property (regRead && supervisor && regAddr <= 8'h08
                         |=> regRdata[31:16] == 16'h0)
        else $error("core register upper bits set");
endmodule

bind two_stage_event_controller two_stage_event_controller_chk u_chk (
    .clock             (clock),
    .rst_b             (rst_b),
    .regRead           (regRead),
    .regAddr           (regAddr),
    .regRdata          (regRdata),
    .supervisor        (supervisor),
    .enableInterrupts  (enableInterrupts),
    .disableInterrupts (disableInterrupts),
    .acceptReady       (acceptReady),
    .coreIdle          (coreIdle),
    .eventTake         (eventTake),
    .eventIndex        (eventIndex),
    .pendingEvents     (pendingEvents),
    .wakeRequest       (wakeRequest)
);

// ---- verif/core_sequencer_model.sv ----
// Sequencer model: accepts entries and returns from them after a delay
`timescale 1ns/1ps

// ==========================================================================
// Sequencer
module core_sequencer_model #(
    parameter int RET_DELAY = 6
) (
    input  wire logic clock,
    input  wire logic rst_b,
    input  wire logic eventTake,
    input  wire logic stall,
    output logic      acceptReady,
    output logic      eventReturn
);
    logic [4:0] depth;
    int         cnt;

    // One return at a time, innermost first
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            acceptReady <= 1'b0;
            eventReturn <= 1'b0;
            depth       <= 5'h00;
            cnt         <= 0;
        end else begin
            acceptReady <= !stall;
            eventReturn <= 1'b0;
            if (depth != 5'h00 && cnt == RET_DELAY) begin
                eventReturn <= 1'b1;
                cnt         <= 0;
                depth       <= depth - 5'h01 + 5'(eventTake);
            end else begin
                cnt   <= (depth != 5'h00) ? cnt + 1 : 0;
                depth <= depth + 5'(eventTake);
            end
        end
    end
endmodule

// ---- verif/two_stage_event_controller_tb_top.sv ----
// Self-checking bench of the two-stage event controller
`timescale 1ns/1ps

// ==========================================================================
// Bench top
module two_stage_event_controller_tb_top;
    typedef struct {
        logic [7:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } row_t;
    logic        clock = 1'b0;
    logic        rst_b = 1'b0;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic        supervisor = 1'b1;
    logic [31:0] peripheralRequest = 32'h0;
    logic [6:0]  dedicatedEvent = 7'h00;
    logic        enableInterrupts = 1'b0;
    logic        disableInterrupts = 1'b0;
    logic        coreIdle = 1'b0;
    logic        stall = 1'b0;
    logic        acceptReady;
    logic        eventReturn;
    logic        eventTake;
    logic [3:0]  eventIndex;
    logic [15:0] pendingEvents;
    logic        wakeRequest;
    logic [31:0] d;
    int          nFail = 0;
    int          checkCount = 0;
    int          cycles = 0;
    int          takes = 0;
    int          lat;
    row_t        rows [7] = '{
        '{8'h0C, 32'h12345678, 32'h12345678},
        '{8'h14, 32'hA5A5A5A5, 32'hA5A5A5A5},
        '{8'h04, 32'hFFFF0F80, 32'h00000F80},
        '{8'h08, 32'h0000FFFF, 32'h0},
        '{8'h10, 32'hFFFFFFFF, 32'h0},
        '{8'h3C, 32'hFFFFFFFF, 32'h0},
        '{8'h24, 32'h76543210, 32'h76543210}
    };

    two_stage_event_controller u_two_stage_event_controller (
        .clock             (clock),
        .rst_b             (rst_b),
        .regWrite          (regWrite),
        .regRead           (regRead),
        .regAddr           (regAddr),
        .regWdata          (regWdata),
        .regRdata          (regRdata),
        .supervisor        (supervisor),
        .peripheralRequest (peripheralRequest),
        .dedicatedEvent    (dedicatedEvent),
        .enableInterrupts  (enableInterrupts),
        .disableInterrupts (disableInterrupts),
        .acceptReady       (acceptReady),
        .eventReturn       (eventReturn),
        .coreIdle          (coreIdle),
        .eventTake         (eventTake),
        .eventIndex        (eventIndex),
        .pendingEvents     (pendingEvents),
        .wakeRequest       (wakeRequest)
    );

    core_sequencer_model u_core_sequencer_model (
        .clock       (clock),
        .rst_b       (rst_b),
        .eventTake   (eventTake),
        .stall       (stall),
        .acceptReady (acceptReady),
        .eventReturn (eventReturn)
    );

    always #5 clock = ~clock;

    // ======================================================================
    // Tasks
    task automatic endSim();
        if (nFail == 0 && checkCount > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, exp);
        checkCount++;
        if (seen !== exp) begin
            nFail++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] w);
        @(negedge clock);
        regWrite = 1'b1;
        regAddr  = a;
        regWdata = w;
        @(negedge clock);
        regWrite = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clock);
        regRead = 1'b0;
        @(negedge clock);
        d = regRdata;
    endtask

    task automatic pulse(input logic en);
        @(negedge clock);
        enableInterrupts  = en;
        disableInterrupts = !en;
        @(negedge clock);
        enableInterrupts  = 1'b0;
        disableInterrupts = 1'b0;
    endtask

    task automatic waitPend(input int idx);
        lat = 0;
        while (pendingEvents[idx] !== 1'b1 && lat < 40) begin
            @(negedge clock);
            lat++;
        end
    endtask

    task automatic waitTake();
        lat = 0;
        do begin
            @(negedge clock);
            lat++;
        end while (eventTake !== 1'b1 && lat < 40);
    endtask

    function automatic logic [31:0] defMap(input int n);
        logic [31:0] v;
        v = 32'h0;
        for (int f = 0; f < 8; f++)
            v[4*f +: 4] = 4'((8 * n + f) % 9);
        return v;
    endfunction

    always @(posedge clock) begin
        cycles++;
        if (eventTake === 1'b1)
            takes++;
        if (cycles == 5000) begin
            nFail++;
            endSim();
        end
    end

    // ======================================================================
    // Main sequence
    initial begin
        repeat (12) @(negedge clock);
        rst_b = 1'b1;
        for (int n = 0; n < 10; n++) begin
            rd(8'(4 * n));
            check(d, n < 6 ? 32'h0 : defMap(n - 6));
        end
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            check(d, rows[i].e);
        end
        // Default routing takes source 3 to position 10
        pulse(1'b1);
        peripheralRequest = 32'h8;
        waitPend(10);
        check(32'(lat inside {[4:8]}), 32'h1);
        check(32'({eventTake, eventIndex}), 32'h1A);
        rd(8'h00);
        check(d, 32'h0);
        rd(8'h10);
        check(d & 32'h8, 32'h8);
        takes = 0;
        repeat (40) @(negedge clock);
        check(32'(takes >= 2), 32'h1);
        peripheralRequest = 32'h0;
        repeat (40) @(negedge clock);
        // Latch writes and the global enable
        pulse(1'b0);
        wr(8'h04, 32'h8F80);
        wr(8'h00, 32'h8000);
        rd(8'h00);
        check(d, 32'h0);
        wr(8'h00, 32'h4000);
        rd(8'h00);
        check(d, 32'h4000);
        wr(8'h00, 32'h0);
        peripheralRequest = 32'h8;
        repeat (10) @(negedge clock);
        rd(8'h00);
        check(d, 32'h0400);
        check(32'(pendingEvents), 32'h0);
        peripheralRequest = 32'h0;
        wr(8'h04, 32'h0B80);
        pulse(1'b1);
        repeat (10) @(negedge clock);
        check(32'(pendingEvents), 32'h0);
        wr(8'h04, 32'h0F80);
        waitPend(10);
        check(32'(pendingEvents[10]), 32'h1);
        repeat (30) @(negedge clock);
        // Supervisor gating
        supervisor = 1'b0;
        wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h04);
        check(d, 32'h0);
        supervisor = 1'b1;
        rd(8'h0C);
        check(d, 32'h12345678);
        // Blocked source still wakes an idle core
        wr(8'h0C, 32'h0);
        wr(8'h14, 32'h8);
        coreIdle = 1'b1;
        peripheralRequest = 32'h8;
        repeat (8) @(negedge clock);
        check(32'(wakeRequest), 32'h1);
        check(32'(pendingEvents), 32'h0);
        coreIdle = 1'b0;
        repeat (2) @(negedge clock);
        check(32'(wakeRequest), 32'h0);
        peripheralRequest = 32'h0;
        // Stalled remapped sources, then nesting
        wr(8'h0C, 32'h28);
        wr(8'h04, 32'h1FC0);
        wr(8'h18, 32'h76540210);
        stall = 1'b1;
        peripheralRequest = 32'h28;
        repeat (12) @(negedge clock);
        peripheralRequest = 32'h0;
        repeat (3) @(negedge clock);
        check(32'(pendingEvents), 32'h0);
        stall = 1'b0;
        waitTake();
        check(32'(eventIndex), 32'h7);
        waitTake();
        check(32'(eventIndex), 32'hC);
        dedicatedEvent = 7'h40;
        waitTake();
        check(32'(pendingEvents), 32'h1040);
        check(32'(eventIndex), 32'h6);
        repeat (20) @(negedge clock);
        endSim();
    end
endmodule
